/* include/t2wav_pkg.sv */
// Constants and types for the timer waveform output block
//
// Notes on behaviour
// - Nonzero output mode hands pin to compare output, except PWM toggle (A needs high bit, B never)
// - Pin driven only when direction bit is output
// - Non-PWM: off, toggle, clear, set on match
// - Fast PWM: match clears/sets, TOP does opposite
// - PWM mode 1 on A toggles only if high bit
// - Phase PWM: up-match and down-match act opposite
// - Compare equal TOP: ignore match, act at TOP
// - Control A bits 3:2 read zero, ignore writes
// - Low mode bits join high bit for mode
// - Mode decode: counting, TOP source, waveform kind
// - Compare reload timing and overflow flag points
// - Phase PWM counts up, one cycle at TOP, counts down
// - Fast PWM wraps to zero after TOP match
package t2wav_pkg;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL_A   = 8'h00;
  localparam logic [7:0] OFS_CTRL_B   = 8'h04;
  localparam logic [7:0] OFS_COUNT    = 8'h08;
  localparam logic [7:0] OFS_CMP_A    = 8'h0c;
  localparam logic [7:0] OFS_CMP_B    = 8'h10;
  localparam logic [7:0] OFS_PIN_DIR  = 8'h14;
  localparam logic [7:0] OFS_STATUS   = 8'h18;
  localparam logic [7:0] OFS_MASK     = 8'h1c;

  // ---------------------------------------------------------------
  // Field positions and masks
  // ---------------------------------------------------------------
  localparam int         CA_COM_A_LSB = 6;
  localparam int         CA_COM_B_LSB = 4;
  localparam logic [7:0] CA_WR_MASK   = 8'hf3;
  localparam int         CB_RUN       = 0;
  localparam int         CB_MODE_HI   = 3;
  localparam logic [7:0] CB_WR_MASK   = 8'h09;
  localparam int         ST_OVF       = 0;
  localparam int         ST_MATCH_A   = 1;
  localparam int         ST_MATCH_B   = 2;
  localparam logic [7:0] REG_RESET    = 8'h00;

  // ---------------------------------------------------------------
  // Counter values and mode codes
  // ---------------------------------------------------------------
  localparam logic [7:0] CNT_MAX      = 8'hff;
  localparam logic [7:0] CNT_BOTTOM   = 8'h00;
  localparam logic [2:0] MODE_NORMAL  = 3'h0;
  localparam logic [2:0] MODE_PC_FF   = 3'h1;
  localparam logic [2:0] MODE_CLR     = 3'h2;
  localparam logic [2:0] MODE_FAST_FF = 3'h3;
  localparam logic [2:0] MODE_PC_CA   = 3'h5;
  localparam logic [2:0] MODE_FAST_CA = 3'h7;
  localparam logic [1:0] COM_OFF      = 2'h0;
  localparam logic [1:0] COM_TOGGLE   = 2'h1;
  localparam logic [1:0] COM_CLEAR    = 2'h2;
  localparam logic [1:0] COM_SET      = 2'h3;

  typedef enum logic [1:0] {
    CLS_NORMAL,
    CLS_CLR,
    CLS_FAST,
    CLS_PHASE
  } t2wav_class_t;

endpackage

/* core/t2wav_core.sv */
// Timer waveform generator with compare outputs and Wishbone registers
`timescale 1ns/1ps
module t2wav_core (
  input  wire logic        i_clk,             // 200 MHz clock
  input  wire logic        i_reset,           // Sync reset, active high
  input  wire logic        i_wb_cyc,          // Bus cycle
  input  wire logic        i_wb_stb,          // Bus strobe
  input  wire logic        i_wb_we,           // Write enable
  input  wire logic [7:0]  i_wb_adr,          // Byte address
  input  wire logic [3:0]  i_wb_sel,          // Byte lanes
  input  wire logic [31:0] i_wb_dat,          // Write data
  output logic      [31:0] o_wb_dat,          // Read data
  output logic             o_wb_ack,          // Acknowledge
  output logic             o_irq,             // Level interrupt
  output logic             o_compare_a_pin,   // Channel A level
  output logic             o_compare_a_oe,    // Channel A drive enable
  output logic             o_compare_a_owns,  // Channel A owns pin
  output logic             o_compare_b_pin,   // Channel B level
  output logic             o_compare_b_oe,    // Channel B drive enable
  output logic             o_compare_b_owns   // Channel B owns pin
);
  import t2wav_pkg::*;

  // ---------------------------------------------------------------
  // Pin update helper
  // ---------------------------------------------------------------
  function automatic logic pin_next(
    input t2wav_class_t cls,
    input logic [1:0]   com,
    input logic         tog_ok,
    input logic         match,
    input logic         top_ev,
    input logic         down,
    input logic         cmp_top,
    input logic         cur
  );
    logic r;
    logic inv;
    r   = cur;
    inv = com[0];
    if (cls == CLS_NORMAL || cls == CLS_CLR) begin
      case (com)
        COM_TOGGLE: if (match) r = ~cur;
        COM_CLEAR:  if (match) r = 1'b0;
        COM_SET:    if (match) r = 1'b1;
        default:    r = cur;
      endcase
    end else if (com == COM_TOGGLE) begin
      if (match && tog_ok) r = ~cur;
    end else if (com[1]) begin
      if (cmp_top) begin
        if (top_ev) r = ~inv;
      end else if (cls == CLS_FAST) begin
        if (match) r = inv;
        else if (top_ev) r = ~inv;
      end else begin
        if (match) r = down ? ~inv : inv;
      end
    end
    return r;
  endfunction

  function automatic logic owns_pin(
    input logic         pwm,
    input logic [1:0]   com,
    input logic         tog_ok
  );
    return (com != COM_OFF) && !(pwm && com == COM_TOGGLE && !tog_ok);
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [7:0]   ctrl_a_q;
  logic [7:0]   ctrl_b_q;
  logic [7:0]   cnt_q;
  logic         down_q;
  logic         blk_q;
  logic [7:0]   buf_a_q;
  logic [7:0]   buf_b_q;
  logic [7:0]   act_a_q;
  logic [7:0]   act_b_q;
  logic [1:0]   dir_q;
  logic [2:0]   status_q;
  logic [2:0]   mask_q;
  logic         pin_a_q;
  logic         pin_b_q;
  logic         ack_q;
  logic [31:0]  rdat_q;

  logic         req;
  logic         wr;
  logic         rd;
  logic [2:0]   mode;
  t2wav_class_t cls;
  logic         pwm;
  logic [7:0]   top;
  logic         tick;
  logic         at_top;
  logic         top_ev;
  logic         match_a;
  logic         match_b;
  logic         ovf_ev;
  logic [1:0]   com_a;
  logic [1:0]   com_b;
  logic         tog_a;
  logic [7:0]   rsel;

  // ---------------------------------------------------------------
  // Bus slave
  // ---------------------------------------------------------------
  assign req = i_wb_cyc && i_wb_stb && !ack_q;
  assign wr  = req && i_wb_we && i_wb_sel[0];
  assign rd  = req && !i_wb_we;

  always_comb begin
    case (i_wb_adr)
      OFS_CTRL_A:  rsel = ctrl_a_q;
      OFS_CTRL_B:  rsel = ctrl_b_q;
      OFS_COUNT:   rsel = cnt_q;
      OFS_CMP_A:   rsel = buf_a_q;
      OFS_CMP_B:   rsel = buf_b_q;
      OFS_PIN_DIR: rsel = {6'h00, dir_q};
      OFS_STATUS:  rsel = {5'h00, status_q};
      OFS_MASK:    rsel = {5'h00, mask_q};
      default:     rsel = 8'h00;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q  <= req;
      rdat_q <= rd ? {24'h00_0000, rsel} : 32'h0000_0000;
    end
  end

  assign o_wb_ack = ack_q;
  assign o_wb_dat = rdat_q;

  // ---------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      ctrl_a_q <= REG_RESET;
      ctrl_b_q <= REG_RESET;
      buf_a_q  <= REG_RESET;
      buf_b_q  <= REG_RESET;
      dir_q    <= 2'h0;
      mask_q   <= 3'h0;
    end else if (wr) begin
      case (i_wb_adr)
        OFS_CTRL_A:  ctrl_a_q <= i_wb_dat[7:0] & CA_WR_MASK;
        OFS_CTRL_B:  ctrl_b_q <= i_wb_dat[7:0] & CB_WR_MASK;
        OFS_CMP_A:   buf_a_q  <= i_wb_dat[7:0];
        OFS_CMP_B:   buf_b_q  <= i_wb_dat[7:0];
        OFS_PIN_DIR: dir_q    <= i_wb_dat[1:0];
        OFS_MASK:    mask_q   <= i_wb_dat[2:0];
        default:     mask_q   <= mask_q;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Mode decode
  // ---------------------------------------------------------------
  // three-bit mode
  assign mode  = {ctrl_b_q[CB_MODE_HI], ctrl_a_q[1:0]};
  assign com_a = ctrl_a_q[CA_COM_A_LSB +: 2];
  assign com_b = ctrl_a_q[CA_COM_B_LSB +: 2];
  assign tog_a = ctrl_b_q[CB_MODE_HI];

  always_comb begin
    case (mode)
      MODE_PC_FF:   begin cls = CLS_PHASE;  top = CNT_MAX; end
      MODE_CLR:     begin cls = CLS_CLR;    top = act_a_q; end
      MODE_FAST_FF: begin cls = CLS_FAST;   top = CNT_MAX; end
      MODE_PC_CA:   begin cls = CLS_PHASE;  top = act_a_q; end
      MODE_FAST_CA: begin cls = CLS_FAST;   top = act_a_q; end
      default:      begin cls = CLS_NORMAL; top = CNT_MAX; end
    endcase
  end

  assign pwm     = (cls == CLS_FAST) || (cls == CLS_PHASE);
  assign tick    = ctrl_b_q[CB_RUN];
  assign at_top  = tick && (cnt_q == top) && !down_q;
  assign top_ev  = at_top && pwm;
  assign match_a = tick && !blk_q && (cnt_q == act_a_q);
  assign match_b = tick && !blk_q && (cnt_q == act_b_q);

  always_comb begin
    if (cls == CLS_PHASE)
      ovf_ev = tick && down_q && (cnt_q == CNT_BOTTOM);
    else if (mode == MODE_FAST_CA)
      ovf_ev = tick && (cnt_q == top);
    else
      ovf_ev = tick && (cnt_q == CNT_MAX);
  end

  // ---------------------------------------------------------------
  // Counter
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      cnt_q  <= CNT_BOTTOM;
      down_q <= 1'b0;
    end else if (wr && i_wb_adr == OFS_COUNT) begin
      cnt_q  <= i_wb_dat[7:0];
    end else if (tick) begin
      case (cls)
        // dual slope, one cycle at ends
        CLS_PHASE: begin
          if (!down_q) begin
            if (cnt_q >= top) begin
              down_q <= (top != CNT_BOTTOM);
              cnt_q  <= (top == CNT_BOTTOM) ? CNT_BOTTOM : cnt_q - 8'h01;
            end else begin
              cnt_q  <= cnt_q + 8'h01;
            end
          end else if (cnt_q == CNT_BOTTOM) begin
            down_q <= 1'b0;
            cnt_q  <= (top == CNT_BOTTOM) ? CNT_BOTTOM : 8'h01;
          end else begin
            cnt_q  <= cnt_q - 8'h01;
          end
        end
        CLS_FAST, CLS_CLR: begin
          down_q <= 1'b0;
          cnt_q  <= (cnt_q == top) ? CNT_BOTTOM : cnt_q + 8'h01;
        end
        default: begin
          down_q <= 1'b0;
          cnt_q  <= cnt_q + 8'h01;
        end
      endcase
    end
  end

  // Counter write blocks the next match
  always_ff @(posedge i_clk) begin
    if (i_reset)
      blk_q <= 1'b0;
    else if (wr && i_wb_adr == OFS_COUNT)
      blk_q <= 1'b1;
    else if (tick)
      blk_q <= 1'b0;
  end

  // ---------------------------------------------------------------
  // Active compare values
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      act_a_q <= REG_RESET;
      act_b_q <= REG_RESET;
    end else if (!pwm || at_top) begin
      act_a_q <= buf_a_q;
      act_b_q <= buf_b_q;
    end
  end

  // ---------------------------------------------------------------
  // Output waveforms
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      pin_a_q <= 1'b0;
      pin_b_q <= 1'b0;
    end else begin
      pin_a_q <= pin_next(cls, com_a, tog_a, match_a, top_ev, down_q,
                          act_a_q == top, pin_a_q);
      pin_b_q <= pin_next(cls, com_b, 1'b0, match_b, top_ev, down_q,
                          act_b_q == top, pin_b_q);
    end
  end

  assign o_compare_a_owns = owns_pin(pwm, com_a, tog_a);
  assign o_compare_b_owns = owns_pin(pwm, com_b, 1'b0);
  // drive only when set as output
  assign o_compare_a_oe   = o_compare_a_owns && dir_q[0];
  assign o_compare_b_oe   = o_compare_b_owns && dir_q[1];
  assign o_compare_a_pin  = pin_a_q;
  assign o_compare_b_pin  = pin_b_q;

  // ---------------------------------------------------------------
  // Interrupt status
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      status_q <= 3'h0;
    end else begin
      // Read clears, new event wins
      status_q <= ((rd && i_wb_adr == OFS_STATUS) ? 3'h0 : status_q)
                | {match_b, match_a, ovf_ev};
    end
  end

  assign o_irq = |(status_q & mask_q);

endmodule // t2wav_core

/* sim/t2wav_chk.sv */
// Bus timing and pin ownership assertions for the waveform block
`timescale 1ns/1ps
module t2wav_chk (
  input wire logic        i_clk,            // Clock
  input wire logic        i_reset,          // Sync reset
  input wire logic        i_wb_stb,         // Bus strobe
  input wire logic        i_wb_cyc,         // Bus cycle
  input wire logic        i_wb_we,          // Write enable
  input wire logic [7:0]  i_wb_adr,         // Byte address
  input wire logic [31:0] o_wb_dat,         // Read data
  input wire logic        o_wb_ack,         // Acknowledge
  input wire logic        o_irq,            // Interrupt
  input wire logic        o_compare_a_oe,   // A drive enable
  input wire logic        o_compare_a_owns, // A owns pin
  input wire logic        o_compare_b_oe,   // B drive enable
  input wire logic        o_compare_b_owns  // B owns pin
);
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (i_reset);

  property p_ack_next;
    i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack;
  endproperty
  a_ack_next: assert property (p_ack_next)
    else $error("ack missing after request");
  property p_ack_pulse;
    o_wb_ack |=> !o_wb_ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack longer than one cycle");
  property p_rdat_idle;
    !o_wb_ack |-> o_wb_dat == 32'h0;
  endproperty
  a_rdat_idle: assert property (p_rdat_idle)
    else $error("read data nonzero without ack");
  property p_res_bits;
    o_wb_ack && !$past(i_wb_we) && $past(i_wb_adr) == 8'h00
      |-> o_wb_dat[3:2] == 2'h0;
  endproperty
  a_res_bits: assert property (p_res_bits)
    else $error("reserved control bits read nonzero");
  property p_oe_a;
    o_compare_a_oe |-> o_compare_a_owns;
  endproperty
  a_oe_a: assert property (p_oe_a)
    else $error("channel a drives without owning pin");
  property p_oe_b;
    o_compare_b_oe |-> o_compare_b_owns;
  endproperty
  a_oe_b: assert property (p_oe_b)
    else $error("channel b drives without owning pin");
  property p_owns_a;
    !$stable(o_compare_a_owns) |-> $past(i_wb_we) && $past(i_wb_stb);
  endproperty
  a_owns_a: assert property (p_owns_a)
    else $error("channel a ownership changed without write");
  property p_irq_fall;
    $fell(o_irq) |-> $past(i_wb_stb);
  endproperty
  a_irq_fall: assert property (p_irq_fall)
    else $error("interrupt dropped without bus access");

  c_oe_a: cover property (o_compare_a_oe);
  c_irq: cover property (o_irq);
  c_oe_b: cover property (o_compare_b_oe);
endmodule // t2wav_chk

bind t2wav_core t2wav_chk u_chk (
  .i_clk(i_clk), .i_reset(i_reset), .i_wb_stb(i_wb_stb),
  .i_wb_cyc(i_wb_cyc), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
  .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .o_irq(o_irq),
  .o_compare_a_oe(o_compare_a_oe), .o_compare_a_owns(o_compare_a_owns),
  .o_compare_b_oe(o_compare_b_oe), .o_compare_b_owns(o_compare_b_owns)
);

/* sim/t2wav_core_tb_top.sv */
// Self-checking bench for the timer waveform block
`timescale 1ns/1ps
module t2wav_core_tb_top;
  import t2wav_pkg::*;
  logic        i_clk = 1'b0;
  logic        i_reset = 1'b1;
  logic        req = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [3:0]  sel = 4'hf;
  logic [31:0] odat;
  logic [31:0] rdat;
  logic        ack, irq, pa, oea, owa, pb, oeb, owb;
  int          failures = 0;
  int          n_tests = 0;
  int          cycles = 0;

  always #2.5 i_clk = ~i_clk;

  t2wav_core DUT (
    .i_clk(i_clk), .i_reset(i_reset), .i_wb_cyc(req), .i_wb_stb(req),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
    .o_wb_dat(odat), .o_wb_ack(ack), .o_irq(irq),
    .o_compare_a_pin(pa), .o_compare_a_oe(oea), .o_compare_a_owns(owa),
    .o_compare_b_pin(pb), .o_compare_b_oe(oeb), .o_compare_b_owns(owb)
  );

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 30000) begin
      failures++;
      finish_test();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // ---------------------------------------------------------------
  // Classic single bus cycle
  // ---------------------------------------------------------------
  task automatic wb(input logic w, input logic [7:0] a, d);
    @(posedge i_clk);
    req  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= {24'h0, d};
    do @(posedge i_clk); while (ack !== 1'b1);
    rdat = odat;
    req  <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, e, input string nm);
    wb(1'b0, a, 8'h00);
    chk(nm, {24'h0, e}, rdat);
  endtask

  // Configure, wait st cycles, count high cycles on both pins over n cycles
  task automatic run(input logic [7:0] ca, m, a, b,
                     input int st, n, ea, eb);
    int ha = 0;
    int hb = 0;
    wb(1'b1, OFS_CTRL_B, 8'h00);
    wb(1'b1, OFS_COUNT, 8'h00);
    wb(1'b1, OFS_CMP_A, a);
    wb(1'b1, OFS_CMP_B, b);
    wb(1'b1, OFS_CTRL_A, ca);
    wb(1'b1, OFS_CTRL_B, m);
    repeat (st) @(posedge i_clk);
    repeat (n) begin
      @(posedge i_clk);
      ha += int'(pa === 1'b1);
      hb += int'(pb === 1'b1);
    end
    chk("pin a high cycles", ea, ha);
    chk("pin b high cycles", eb, hb);
    $display("test ctrl %h %h done", ca, m);
  endtask

  initial begin
    repeat (12) @(posedge i_clk);
    i_reset <= 1'b0;
    for (int i = 0; i < 8; i++) rd(8'(i * 4), 8'h00, "reset value");
    wb(1'b1, OFS_CTRL_A, 8'hff);
    rd(OFS_CTRL_A, 8'hf3, "ctrl a");
    wb(1'b1, OFS_CTRL_B, 8'hff);
    rd(OFS_CTRL_B, 8'h09, "ctrl b");
    wb(1'b1, 8'h20, 8'h5a);
    rd(8'h20, 8'h00, "unmapped");
    sel <= 4'h0;
    wb(1'b1, OFS_MASK, 8'h07);
    sel <= 4'hf;
    rd(OFS_MASK, 8'h00, "lane zero write ignored");
    wb(1'b1, OFS_CTRL_B, 8'h00);
    wb(1'b1, OFS_CTRL_A, 8'h40);
    chk("pins", 32'h8, {owa, oea, owb, oeb});
    wb(1'b1, OFS_PIN_DIR, 8'h01);
    chk("pins", 32'hc, {owa, oea, owb, oeb});
    wb(1'b1, OFS_CTRL_A, 8'h51);
    chk("pins", 32'h0, {owa, oea, owb, oeb});
    wb(1'b1, OFS_CTRL_B, 8'h08);
    chk("pins", 32'hc, {owa, oea, owb, oeb});
    $display("test registers done");
    wb(1'b1, OFS_PIN_DIR, 8'h03);
    wb(1'b1, OFS_CTRL_A, 8'h00);
    wb(1'b1, OFS_COUNT, 8'hf0);
    wb(1'b1, OFS_CTRL_B, 8'h01);
    repeat (40) @(posedge i_clk);
    chk("irq masked", 32'h0, {31'h0, irq});
    wb(1'b1, OFS_CTRL_B, 8'h00);
    wb(1'b1, OFS_MASK, 8'h01);
    chk("irq raised", 32'h1, {31'h0, irq});
    wb(1'b0, OFS_STATUS, 8'h00);
    chk("overflow flag", 32'h1, {31'h0, rdat[0]});
    chk("irq cleared", 32'h0, {31'h0, irq});
    $display("test interrupt done");
    run(8'h70, 8'h01, 8'h02, 8'h02, 1100, 512, 256, 512);
    run(8'h60, 8'h01, 8'h02, 8'h02, 1100, 512, 256, 0);
    run(8'h52, 8'h01, 8'h09, 8'h03, 60, 200, 100, 100);
    run(8'hb3, 8'h01, 8'h02, 8'h02, 1100, 512, 6, 506);
    run(8'hb1, 8'h01, 8'h02, 8'h02, 1100, 1020, 8, 1012);
    run(8'h63, 8'h09, 8'h09, 8'h03, 60, 200, 100, 80);
    run(8'h61, 8'h09, 8'h09, 8'h03, 60, 180, 90, 60);
    run(8'hb3, 8'h01, 8'hff, 8'hff, 1100, 512, 512, 0);
    run(8'hb1, 8'h01, 8'hff, 8'hff, 1100, 1020, 1020, 0);
    finish_test();
  end
endmodule // t2wav_core_tb_top
